// file: core/pmu_bus_if.sv
`timescale 1ns/1ps
`default_nettype none

module pmu_bus_if
    import pmu_pkg::*;
#(
    parameter int ENTRIES = CACHE_ENTRIES
)
(
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    // CPU address/data bus
    input  wire logic                addr_strobe_n_i,
    input  wire logic [HI_BUS_W-1:0] high_addr_bus_i,
    output logic      [HI_BUS_W-1:0] high_addr_bus_o,
    output logic                     high_addr_bus_oe_o,
    input  wire logic [LO_BUS_W-1:0] low_addr_data_bus_i,
    output logic      [LO_BUS_W-1:0] low_addr_data_bus_o,
    output logic                     low_addr_data_bus_oe_o,
    input  wire logic                data_dir_in_n_i,
    output logic                     data_dir_in_n_o,
    output logic                     data_dir_in_n_oe_o,
    input  wire logic                ready_i,
    // CPU status
    input  wire logic                user_mode_i,
    input  wire logic [STATUS_W-1:0] bus_status_i,
    input  wire logic                instr_flow_pulse_n_i,
    // Bus handover
    input  wire logic                hold_req_n_i,
    input  wire logic                hold_ack_in_n_i,
    output logic                     hold_ack_out_n_o,
    output logic                     cpu_float_n_o,
    // Shared translation/coprocessor strobe
    input  wire logic                xlate_coproc_strobe_n_i,
    output logic                     xlate_coproc_strobe_n_o,
    output logic                     xlate_coproc_strobe_n_oe_o,
    // Control outputs
    output logic                     reset_or_abort_n_o,
    output logic                     phys_addr_valid_n_o,
    output logic                     break_n_o,
    // Configuration strap
    input  wire logic                top_addr_cfg_i,
    output logic                     top_addr_cfg_o,
    output logic                     top_addr_cfg_oe_o,
    output logic                     cfg_cpu16_o,
    // Page table bases per address space
    input  wire logic [LADDR_W-1:0]  table_base_user_i,
    input  wire logic [LADDR_W-1:0]  table_base_super_i,
    // Page status
    output pmu_fault_t               fault_status_o
);

    localparam int BP_IDX_W = (BP_COUNT > 1) ? $clog2(BP_COUNT) : 1;

    generate
        if (BP_COUNT < 1)
        begin : g_bad_bp
            $error("BP_COUNT must be at least 1");
        end
    endgenerate

    function automatic logic is_slave_xfer(input logic [STATUS_W-1:0] st);
        is_slave_xfer = (st == BST_SLAVE_XFER);
    endfunction

    pmu_state_t          state;
    pmu_state_t          next_state;
    logic [LADDR_W-1:0]  laddr;
    logic                user_lat;
    logic                write_lat;
    pmu_tag_t            look_tag;
    logic                look_hit;
    pmu_xlat_t           look_data;
    logic                hit_q;
    pmu_xlat_t           xlat_q;
    logic                nr_pending;
    logic                prot_fault;
    logic                fault_now;
    logic                walking;
    logic                walk_word;
    logic [LO_BUS_W-1:0] pte_word0;
    logic                fill;
    pmu_xlat_t           fill_data;
    logic [LADDR_W-1:0]  out_addr;
    logic [LADDR_W-1:0]  pte_addr;
    logic [LO_BUS_W-1:0] bp_reg [BP_COUNT];
    logic [BP_COUNT-1:0] bp_match;
    logic                bp_fired;
    logic                pfs_prev;
    logic                strobe_prev;
    logic                strobe_fall;
    logic [BP_IDX_W-1:0] wr_idx;
    logic [BP_IDX_W-1:0] rd_idx;
    logic                done_q;
    logic                rd_drive;
    logic [LO_BUS_W-1:0] coproc_rd;

    // Lookup runs on the live bus during T1 so the result is ready at translation start
    assign look_tag = (state == ST_IDLE)
                    ? {user_mode_i, high_addr_bus_i, low_addr_data_bus_i[LO_BUS_W-1:PAGE_OFS_W]}
                    : {user_lat, laddr[LADDR_W-1:PAGE_OFS_W]};

    pmu_xlate_cache #(
        .ENTRIES     (ENTRIES)
    ) u_cache (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .look_tag_i  (look_tag),
        .hit_o       (look_hit),
        .look_data_o (look_data),
        .fill_i      (fill),
        .fill_tag_i  ({user_lat, laddr[LADDR_W-1:PAGE_OFS_W]}),
        .fill_data_i (fill_data)
    );

    assign prot_fault = hit_q && ((user_lat && !xlat_q.user_ok) || (write_lat && !xlat_q.write_ok));
    assign fault_now  = nr_pending || prot_fault;
    assign walking    = (state == ST_WADDR) || (state == ST_WDATA) || (state == ST_REFILLED);
    assign fill       = (state == ST_WDATA) && ready_i && walk_word;
    assign fill_data  = {pte_word0[PFN_W-1:0],
                         low_addr_data_bus_i[PTE_USER_OK_BIT],
                         low_addr_data_bus_i[PTE_WRITE_OK_BIT]};
    assign pte_addr   = ((user_lat ? table_base_user_i : table_base_super_i)
                      + {{(LADDR_W - VPN_W - PTE_INDEX_SHIFT){1'b0}}, laddr[LADDR_W-1:PAGE_OFS_W],
                         {PTE_INDEX_SHIFT{1'b0}}})
                      + ((state == ST_WDATA) ? PTE_WORD1_OFS : ADDR_RESET);

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (!addr_strobe_n_i)
                    next_state = ST_TRANSLATE_PERIOD;
            ST_TRANSLATE_PERIOD:
                if (!hit_q && !nr_pending)
                begin
                    if (hold_ack_out_n_o)
                        next_state = ST_WADDR;
                end
                else if (fault_now)
                    next_state = ST_IDLE;
                else
                    next_state = ST_T2;
            ST_T2:
                next_state = ST_T3;
            ST_T3:
                if (ready_i)
                    next_state = ST_T4;
            ST_T4:
                next_state = ST_IDLE;
            ST_WADDR:
                next_state = ST_WDATA;
            ST_WDATA:
                if (ready_i)
                begin
                    if (!walk_word && !low_addr_data_bus_i[PTE_VALID_BIT])
                        next_state = ST_REFILLED;
                    else if (!walk_word)
                        next_state = ST_WADDR;
                    else
                        next_state = ST_REFILLED;
                end
            ST_REFILLED:
                next_state = ST_TRANSLATE_PERIOD;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // Logical address capture
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            laddr     <= ADDR_RESET;
            user_lat  <= 1'b0;
            write_lat <= 1'b0;
        end
        else if (state == ST_IDLE && !addr_strobe_n_i)
        begin
            laddr     <= {high_addr_bus_i, low_addr_data_bus_i};
            user_lat  <= user_mode_i;
            write_lat <= data_dir_in_n_i;
        end
    end

    // Registered lookup result and output address
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            hit_q    <= 1'b0;
            xlat_q   <= '0;
            out_addr <= ADDR_RESET;
        end
        else if (next_state == ST_TRANSLATE_PERIOD && state != ST_TRANSLATE_PERIOD)
        begin
            hit_q    <= look_hit;
            xlat_q   <= look_data;
            out_addr <= {look_data.pfn,
                         (state == ST_IDLE) ? low_addr_data_bus_i[PAGE_OFS_W-1:0]
                                            : laddr[PAGE_OFS_W-1:0]};
        end
        else if (next_state == ST_WADDR)
            out_addr <= pte_addr;
    end

    // Table walk bookkeeping
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            walk_word  <= 1'b0;
            pte_word0  <= '0;
            nr_pending <= 1'b0;
        end
        else
        begin
            if (state == ST_WDATA && ready_i)
            begin
                walk_word <= ~walk_word;
                if (!walk_word)
                begin
                    pte_word0 <= low_addr_data_bus_i;
                    if (!low_addr_data_bus_i[PTE_VALID_BIT])
                    begin
                        nr_pending <= 1'b1;
                        walk_word  <= 1'b0;
                    end
                end
            end
            if (state == ST_TRANSLATE_PERIOD && next_state != ST_TRANSLATE_PERIOD)
                nr_pending <= 1'b0;
        end
    end

    // Page status for the operating system
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            fault_status_o <= '0;
        else if (state == ST_TRANSLATE_PERIOD && fault_now)
            fault_status_o <= {nr_pending, prot_fault && !nr_pending, user_lat,
                               laddr[LADDR_W-1:PAGE_OFS_W]};
    end

    // Bus handover; no grant while the table walk owns the bus
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            hold_ack_out_n_o <= 1'b1;
        else
            hold_ack_out_n_o <= !(!hold_req_n_i && !hold_ack_in_n_i && !walking
                                  && next_state != ST_WADDR);
    end

    // Breakpoints fire at most once per instruction
    genvar gb;
    generate
        for (gb = 0; gb < BP_COUNT; gb++)
        begin : g_bp
            assign bp_match[gb] = bp_reg[gb][BP_ENABLE_BIT]
                               && (bp_reg[gb][VPN_W-1:0] == look_tag.vpn);
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            pfs_prev  <= 1'b1;
            bp_fired  <= 1'b0;
            break_n_o <= 1'b1;
        end
        else
        begin
            pfs_prev  <= instr_flow_pulse_n_i;
            break_n_o <= 1'b1;
            if (state == ST_IDLE && !addr_strobe_n_i && |bp_match && !bp_fired)
            begin
                break_n_o <= 1'b0;
                bp_fired  <= 1'b1;
            end
            else if (pfs_prev && !instr_flow_pulse_n_i)
                bp_fired  <= 1'b0;
        end
    end

    // Coprocessor transfers load and read the breakpoint registers
    assign strobe_fall = strobe_prev && !xlate_coproc_strobe_n_i && !done_q
                      && is_slave_xfer(bus_status_i);

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            strobe_prev <= 1'b1;
            wr_idx      <= '0;
            rd_idx      <= '0;
            done_q      <= 1'b0;
            rd_drive    <= 1'b0;
            coproc_rd   <= BP_RESET;
            for (int i = 0; i < BP_COUNT; i++)
                bp_reg[i] <= BP_RESET;
        end
        else
        begin
            strobe_prev <= xlate_coproc_strobe_n_i || done_q;
            done_q      <= 1'b0;
            if (xlate_coproc_strobe_n_i)
                rd_drive <= 1'b0;
            if (strobe_fall && data_dir_in_n_i)
            begin
                bp_reg[wr_idx] <= low_addr_data_bus_i;
                if (wr_idx == BP_IDX_W'(BP_COUNT - 1))
                begin
                    wr_idx <= '0;
                    done_q <= 1'b1;
                end
                else
                    wr_idx <= BP_IDX_W'(wr_idx + 1'b1);
            end
            else if (strobe_fall)
            begin
                coproc_rd <= bp_reg[rd_idx];
                rd_drive  <= 1'b1;
                rd_idx    <= (rd_idx == BP_IDX_W'(BP_COUNT - 1)) ? '0 : BP_IDX_W'(rd_idx + 1'b1);
            end
        end
    end

    // Strap is caught while reset is held
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            cfg_cpu16_o <= top_addr_cfg_i;
    end

    // Pin drive
    logic drive_phys;
    logic drive_walk_addr;

    assign drive_phys      = hit_q && !fault_now
                          && ((state == ST_TRANSLATE_PERIOD) || (state == ST_T2) || (state == ST_T3) || (state == ST_T4));
    assign drive_walk_addr = (state == ST_WADDR);

    assign high_addr_bus_o        = out_addr[LADDR_W-1:LO_BUS_W];
    assign high_addr_bus_oe_o     = drive_phys || drive_walk_addr;
    assign low_addr_data_bus_o    = rd_drive ? coproc_rd : out_addr[LO_BUS_W-1:0];
    assign low_addr_data_bus_oe_o = rd_drive || drive_walk_addr
                                 || (state == ST_TRANSLATE_PERIOD && drive_phys);
    assign top_addr_cfg_o         = 1'b0;
    assign top_addr_cfg_oe_o      = high_addr_bus_oe_o;
    assign data_dir_in_n_o        = 1'b0;
    assign data_dir_in_n_oe_o     = (state == ST_WADDR) || (state == ST_WDATA);
    assign cpu_float_n_o          = !walking;
    assign phys_addr_valid_n_o    = !(state == ST_TRANSLATE_PERIOD && drive_phys);
    assign reset_or_abort_n_o     = !(state == ST_TRANSLATE_PERIOD && fault_now && !(!hit_q && !nr_pending));
    assign xlate_coproc_strobe_n_o    = 1'b0;
    assign xlate_coproc_strobe_n_oe_o = done_q;

endmodule

`default_nettype wire

// file: core/pmu_pkg.sv
package pmu_pkg;

    // Address geometry
    localparam int LADDR_W        = 24;
    localparam int PAGE_OFS_W     = 9;
    localparam int VPN_W          = LADDR_W - PAGE_OFS_W;
    localparam int PFN_W          = 15;
    localparam int HI_BUS_W       = 8;
    localparam int LO_BUS_W       = 16;
    localparam int STATUS_W       = 4;

    // Translation cache and breakpoints
    localparam int CACHE_ENTRIES  = 32;
    localparam int BP_COUNT       = 2;
    localparam int BP_ENABLE_BIT  = 15;

    // Page table entry layout, two 16-bit words per page
    localparam int PTE_VALID_BIT    = 15;
    localparam int PTE_USER_OK_BIT  = 0;
    localparam int PTE_WRITE_OK_BIT = 1;
    localparam int PTE_INDEX_SHIFT  = 2;
    localparam logic [LADDR_W-1:0] PTE_WORD1_OFS = 24'h000002;

    // Bus status code of a slave (coprocessor) transfer
    localparam logic [STATUS_W-1:0] BST_SLAVE_XFER = 4'hD;

    // Reset values
    localparam logic [LO_BUS_W-1:0] BP_RESET = 16'h0000;
    localparam logic [LADDR_W-1:0]  ADDR_RESET = 24'h000000;

    typedef struct packed {
        logic             space;
        logic [VPN_W-1:0] vpn;
    } pmu_tag_t;

    typedef struct packed {
        logic [PFN_W-1:0] pfn;
        logic             user_ok;
        logic             write_ok;
    } pmu_xlat_t;

    typedef struct packed {
        logic     nonresident;
        logic     protect;
        pmu_tag_t tag;
    } pmu_fault_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_TRANSLATE_PERIOD,
        ST_T2,
        ST_T3,
        ST_T4,
        ST_WADDR,
        ST_WDATA,
        ST_REFILLED
    } pmu_state_t;

endpackage

// file: core/pmu_xlate_cache.sv
`timescale 1ns/1ps
`default_nettype none

module pmu_xlate_cache
    import pmu_pkg::*;
#(
    parameter int ENTRIES = CACHE_ENTRIES
)
(
    // Clock and reset
    input  wire logic      clk_i,
    input  wire logic      rst_b_i,
    // Lookup
    input  wire pmu_tag_t  look_tag_i,
    output logic           hit_o,
    output pmu_xlat_t      look_data_o,
    // Refill
    input  wire logic      fill_i,
    input  wire pmu_tag_t  fill_tag_i,
    input  wire pmu_xlat_t fill_data_i
);

    localparam int IDX_W = $clog2(ENTRIES);

    generate
        if (ENTRIES < 2 || (1 << IDX_W) != ENTRIES)
        begin : g_bad_entries
            $error("ENTRIES must be a power of two of at least 2");
        end
    endgenerate

    logic                    valid [ENTRIES];
    pmu_tag_t                tags  [ENTRIES];
    pmu_xlat_t               datas [ENTRIES];
    logic [IDX_W-1:0]        repl_ptr;
    logic [ENTRIES-1:0]      match;

    genvar gi;
    generate
        for (gi = 0; gi < ENTRIES; gi++)
        begin : g_match
            assign match[gi] = valid[gi] && (tags[gi] == look_tag_i);
        end
    endgenerate

    always_comb
    begin
        hit_o       = 1'b0;
        look_data_o = '0;
        for (int i = 0; i < ENTRIES; i++)
        begin
            if (match[i] && !hit_o)
            begin
                hit_o       = 1'b1;
                look_data_o = datas[i];
            end
        end
    end

    // Round-robin replacement keeps the refill path free of age tracking
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            repl_ptr <= '0;
            for (int i = 0; i < ENTRIES; i++)
            begin
                valid[i] <= 1'b0;
                tags[i]  <= '0;
                datas[i] <= '0;
            end
        end
        else if (fill_i)
        begin
            valid[repl_ptr] <= 1'b1;
            tags[repl_ptr]  <= fill_tag_i;
            datas[repl_ptr] <= fill_data_i;
            repl_ptr        <= IDX_W'(repl_ptr + 1'b1);
        end
    end

endmodule

`default_nettype wire

// file: bench/pmu_bus_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pmu_bus_chk
    import pmu_pkg::*;
(
    // Clock and reset
    input wire logic                clk_i,
    input wire logic                rst_b_i,
    // Watched outputs
    input wire logic                phys_addr_valid_n_o,
    input wire logic                reset_or_abort_n_o,
    input wire logic                cpu_float_n_o,
    input wire logic                high_addr_bus_oe_o,
    input wire logic [HI_BUS_W-1:0] high_addr_bus_o,
    input wire logic                low_addr_data_bus_oe_o,
    input wire logic                data_dir_in_n_oe_o,
    input wire logic                data_dir_in_n_o,
    input wire logic                xlate_coproc_strobe_n_oe_o,
    input wire logic                xlate_coproc_strobe_n_o,
    input wire logic                break_n_o,
    input wire logic                hold_ack_out_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    property p_reset_quiet;
        $rose(rst_b_i) |-> !high_addr_bus_oe_o && !low_addr_data_bus_oe_o && phys_addr_valid_n_o
            && reset_or_abort_n_o && break_n_o && hold_ack_out_n_o && cpu_float_n_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
    property p_valid_excl;
        !phys_addr_valid_n_o |-> reset_or_abort_n_o && cpu_float_n_o;
    endproperty
    a_valid_excl: assert property (p_valid_excl) else $error("valid with abort or float");
    property p_valid_pulse;
        !phys_addr_valid_n_o |=> phys_addr_valid_n_o;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("valid pulse too long");
    property p_valid_bus;
        !phys_addr_valid_n_o |-> high_addr_bus_oe_o && low_addr_data_bus_oe_o;
    endproperty
    a_valid_bus: assert property (p_valid_bus) else $error("address not driven");
    // At least T2, T3 and T4 follow; stalls only stretch T3
    property p_high_hold;
        !phys_addr_valid_n_o |=> (high_addr_bus_oe_o && $stable(high_addr_bus_o) && !low_addr_data_bus_oe_o) [*3];
    endproperty
    a_high_hold: assert property (p_high_hold) else $error("high address not held");
    property p_abort_pulse;
        !reset_or_abort_n_o |=> reset_or_abort_n_o;
    endproperty
    a_abort_pulse: assert property (p_abort_pulse) else $error("abort pulse too long");
    property p_abort_when;
        !reset_or_abort_n_o |-> cpu_float_n_o && !data_dir_in_n_oe_o;
    endproperty
    a_abort_when: assert property (p_abort_when) else $error("abort during walk");
    property p_dir_own;
        data_dir_in_n_oe_o |-> !cpu_float_n_o && !data_dir_in_n_o;
    endproperty
    a_dir_own: assert property (p_dir_own) else $error("direction driven badly");
    property p_done_pulse;
        xlate_coproc_strobe_n_oe_o |-> !xlate_coproc_strobe_n_o ##1 !xlate_coproc_strobe_n_oe_o;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("completion pulse bad");
    property p_break_pulse;
        !break_n_o |=> break_n_o;
    endproperty
    a_break_pulse: assert property (p_break_pulse) else $error("break pulse too long");
endmodule
`default_nettype wire

// file: bench/pmu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmu_mem_model
(
    // Clock
    input  wire logic        clk_i,
    // Device side
    input  wire logic        float_n_i,
    input  wire logic        hi_oe_i,
    input  wire logic [7:0]  hi_i,
    input  wire logic        lo_oe_i,
    input  wire logic [15:0] lo_i,
    // Processor side
    input  wire logic        cpu_oe_i,
    input  wire logic [7:0]  cpu_hi_i,
    input  wire logic [15:0] cpu_lo_i,
    // Resolved buses
    output logic      [7:0]  hi_bus_o,
    output logic      [15:0] lo_bus_o
);
    logic [15:0] mem [logic [23:0]];
    logic [23:0] walk_addr = 24'h000000;
    logic [15:0] lo_last = 16'h0000;
    logic [7:0]  hi_last = 8'h00;
    logic [15:0] rd_word;

    always @*
    begin
        rd_word = 16'h0000;
        if (mem.exists(walk_addr))
            rd_word = mem[walk_addr];
    end

    // Released lines flip each cycle so a stale value never passes
    always @*
    begin
        if (lo_oe_i)
            lo_bus_o = lo_i;
        else if (cpu_oe_i)
            lo_bus_o = cpu_lo_i;
        else if (!float_n_i)
            lo_bus_o = rd_word;
        else
            lo_bus_o = ~lo_last;
        if (hi_oe_i)
            hi_bus_o = hi_i;
        else if (cpu_oe_i)
            hi_bus_o = cpu_hi_i;
        else
            hi_bus_o = ~hi_last;
    end

    always @(posedge clk_i)
    begin
        lo_last <= lo_bus_o;
        hi_last <= hi_bus_o;
        if (!float_n_i && lo_oe_i)
            walk_addr <= {hi_i, lo_i};
    end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pmu_pkg::*;
;
    logic clk_i = 1'b0, rst_b_i = 1'b0, astb_n = 1'b1, cpu_oe = 1'b0, cpu_dir = 1'b0, ready = 1'b1;
    logic user = 1'b0, flow_n = 1'b1, hold_req_n = 1'b1, hold_ack_in_n = 1'b1, cstb_n = 1'b1, strap = 1'b1;
    logic [7:0] cpu_hi = 8'h00, hi_o, hi_bus;
    logic [15:0] cpu_lo = 16'h0000, lo_o, lo_bus;
    logic [3:0] status = 4'h0;
    logic hi_oe, lo_oe, dir_o, dir_oe, strb_o, strb_oe, cfg_o, cfg_oe, cfg16, hack_n, float_n, abt_n, pvalid_n, brk_n;
    logic r_pav, r_flt, r_brk;
    logic [23:0] r_phys;
    int r_n, n_errors = 0, comparisons = 0, cycles = 0;
    pmu_fault_t fstat;
    wire logic dir_bus = dir_oe ? dir_o : cpu_dir;
    wire logic strb_bus = strb_oe ? strb_o : cstb_n;
    wire logic cfg_bus = cfg_oe ? cfg_o : strap;

    always #2 clk_i = ~clk_i;

    pmu_mem_model pm (.clk_i(clk_i), .float_n_i(float_n), .hi_oe_i(hi_oe), .hi_i(hi_o), .lo_oe_i(lo_oe),
        .lo_i(lo_o), .cpu_oe_i(cpu_oe), .cpu_hi_i(cpu_hi), .cpu_lo_i(cpu_lo), .hi_bus_o(hi_bus), .lo_bus_o(lo_bus));

    pmu_bus_if dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_strobe_n_i(astb_n), .high_addr_bus_i(hi_bus),
        .high_addr_bus_o(hi_o), .high_addr_bus_oe_o(hi_oe), .low_addr_data_bus_i(lo_bus),
        .low_addr_data_bus_o(lo_o), .low_addr_data_bus_oe_o(lo_oe), .data_dir_in_n_i(dir_bus),
        .data_dir_in_n_o(dir_o), .data_dir_in_n_oe_o(dir_oe), .ready_i(ready), .user_mode_i(user),
        .bus_status_i(status), .instr_flow_pulse_n_i(flow_n), .hold_req_n_i(hold_req_n),
        .hold_ack_in_n_i(hold_ack_in_n), .hold_ack_out_n_o(hack_n), .cpu_float_n_o(float_n),
        .xlate_coproc_strobe_n_i(strb_bus), .xlate_coproc_strobe_n_o(strb_o),
        .xlate_coproc_strobe_n_oe_o(strb_oe), .reset_or_abort_n_o(abt_n), .phys_addr_valid_n_o(pvalid_n),
        .break_n_o(brk_n), .top_addr_cfg_i(cfg_bus), .top_addr_cfg_o(cfg_o), .top_addr_cfg_oe_o(cfg_oe),
        .cfg_cpu16_o(cfg16), .table_base_user_i(24'h020000), .table_base_super_i(24'h010000),
        .fault_status_o(fstat));

    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    task automatic end_of_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            end_of_test;
        end
    end

    task automatic do_reset(input logic v);
        rst_b_i = 1'b0;
        strap = v;
        repeat (3) tick;
        rst_b_i = 1'b1;
        chk("strap copy", {23'h0, v}, {23'h0, cfg16});
        chk("reset outputs", 24'h00001F, {19'h0, hack_n, float_n, abt_n, pvalid_n, brk_n});
    endtask

    task automatic cpu_cycle(input logic [23:0] a, input logic u, input logic w, input int s);
        int k;
        k = 0;
        r_flt = 1'b0;
        r_brk = 1'b0;
        r_n = 0;
        cpu_hi = a[23:16];
        cpu_lo = a[15:0];
        cpu_oe = 1'b1;
        astb_n = 1'b0;
        user = u;
        cpu_dir = w;
        ready = (s == 0);
        tick;
        astb_n = 1'b1;
        cpu_oe = 1'b0;
        while (pvalid_n && abt_n && k < 20)
        begin
            r_flt |= !float_n;
            tick;
            k++;
        end
        r_pav = !pvalid_n;
        r_phys = {hi_o, lo_o};
        do
        begin
            r_brk |= !brk_n;
            r_n++;
            if (r_n == 3 + s)
                ready = 1'b1;
            tick;
        end
        while (hi_oe && r_n < 30);
        ready = 1'b1;
    endtask

    task automatic cp_write(input logic [15:0] d, input logic exp_done, input logic w);
        logic seen;
        seen = 1'b0;
        status = BST_SLAVE_XFER;
        cpu_lo = d;
        cpu_oe = w;
        cpu_dir = w;
        cstb_n = 1'b0;
        tick;
        if (!w) chk("coproc read", {8'h01, d}, {7'h0, lo_oe, lo_o});
        cstb_n = 1'b1;
        cpu_oe = 1'b0;
        status = 4'h0;
        repeat (3)
        begin
            seen |= strb_oe && !strb_o;
            tick;
        end
        chk("completion pulse", {23'h0, exp_done}, {23'h0, seen});
    endtask

    task automatic pulse_flow;
        flow_n = 1'b0;
        tick;
        flow_n = 1'b1;
        tick;
    endtask

    task automatic s_translate;
        cpu_cycle(24'h001234, 1'b0, 1'b0, 0);
        chk("walk float", 24'h1, {23'h0, r_flt});
        chk("walk phys", 24'h02AA34, r_phys);
        chk("cycle length", 24'h4, r_n[23:0]);
        cpu_cycle(24'h001234, 1'b0, 1'b1, 2);
        chk("hit float", 24'h0, {23'h0, r_flt});
        chk("hit valid", 24'h1, {23'h0, r_pav});
        chk("stalled length", 24'h6, r_n[23:0]);
    endtask

    task automatic s_protect;
        cpu_cycle(24'h000410, 1'b1, 1'b1, 0);
        chk("write read-only", 24'h0, {23'h0, r_pav});
        chk("protect status", {6'h0, 1'b0, 1'b1, 1'b1, 15'h0002}, {6'h0, fstat});
        cpu_cycle(24'h0005FF, 1'b1, 1'b0, 0);
        chk("page end phys", 24'h000FFF, r_phys);
        cpu_cycle(24'h000410, 1'b0, 1'b0, 0);
        chk("other space", {6'h0, 1'b1, 1'b0, 1'b0, 15'h0002}, {6'h0, fstat});
        cpu_cycle(24'h000600, 1'b1, 1'b0, 0);
        chk("next page absent", 24'h0, {23'h0, r_pav});
    endtask

    task automatic s_break;
        cp_write(16'h8009, 1'b0, 1'b1);
        cp_write(16'h0000, 1'b1, 1'b1);
        cp_write(16'h8009, 1'b0, 1'b0);
        pulse_flow;
        cpu_cycle(24'h001200, 1'b0, 1'b0, 0);
        chk("break on match", 24'h1, {23'h0, r_brk});
        cpu_cycle(24'h001200, 1'b0, 1'b0, 0);
        chk("break once", 24'h0, {23'h0, r_brk});
        pulse_flow;
        cpu_cycle(24'h000410, 1'b1, 1'b0, 0);
        chk("no break elsewhere", 24'h0, {23'h0, r_brk});
    endtask

    task automatic s_hold;
        int k;
        k = 0;
        hold_req_n = 1'b0;
        hold_ack_in_n = 1'b0;
        while (hack_n !== 1'b0 && k < 5)
        begin
            tick;
            k++;
        end
        chk("hold ack", 24'h0, {23'h0, hack_n});
        hold_req_n = 1'b1;
        hold_ack_in_n = 1'b1;
        repeat (5) tick;
        chk("hold ack release", 24'h1, {23'h0, hack_n});
    endtask

    initial
    begin
        pm.mem[24'h010024] = 16'h8155;
        pm.mem[24'h010026] = 16'h0003;
        pm.mem[24'h020008] = 16'h8007;
        pm.mem[24'h02000A] = 16'h0001;
        do_reset(1'b1);
        s_translate;
        s_protect;
        s_break;
        s_hold;
        do_reset(1'b0);
        end_of_test;
    end
endmodule

bind pmu_bus_if pmu_bus_chk u_chk (.clk_i, .rst_b_i, .phys_addr_valid_n_o, .reset_or_abort_n_o, .cpu_float_n_o,
    .high_addr_bus_oe_o, .high_addr_bus_o, .low_addr_data_bus_oe_o, .data_dir_in_n_oe_o, .data_dir_in_n_o,
    .xlate_coproc_strobe_n_oe_o, .xlate_coproc_strobe_n_o, .break_n_o, .hold_ack_out_n_o);
`default_nettype wire
